// File: hdl/spd_power_down_ctrl.sv
// power-down control register and suspend wake-window sequencer
//
// What this block does
// - power-down control register sits at offset 0354h for power saving
// - bits 31:16 set the wake window before suspend is re-entered
// - suspend returns only if software has not restored normal operation
// - window resets to 03E8h (10 ms) in 32-bit mode
// - window zero means wake events are ignored, stay suspended
// - FFFFh is the largest window, about 655 ms
// - each count is one 10 us period of the low-power slow clock
// - window resets to 17E8h in 16-bit bus mode
// - 16-bit mode write to window bits forces 1400h (51.2 ms)
// - bit 12 connects port 3 pull-down resistors when set
// - bit 11 connects port 2 pull-down resistors when set
// - bit 10 set powers the supply detector down during suspend
`timescale 1ns/1ps
`default_nettype none
module spd_power_down_ctrl
(
   input  wire logic                 i_clk,
   input  wire logic                 i_reset,
   input  wire logic                 i_bus16_mode,
   input  wire spd_pkg::spd_bus_type i_bus,
   output logic [31:0]               o_rdata,
   input  wire logic                 i_enter_suspend,
   input  wire logic                 i_wake_event,
   input  wire logic                 i_resume_normal,
   input  wire logic                 i_low_power_slow_clock,
   output logic                      o_suspend,
   output logic                      o_port3_pulldown_en,
   output logic                      o_port2_pulldown_en,
   output logic                      o_supply_detector_on
);
   import spd_pkg::*;

   spd_ctrl_type  ctrl_r;
   spd_state_type state_r;
   logic          mode16_r;
   logic          slow_clk_r;
   logic          slow_tick;
   logic          hit;
   logic          wr_hi;
   logic          wr_lo;
   logic          load;
   logic          cancel;
   logic          expired;
   logic          timer_running;

   // ----------------------------------------------------------------
   // decode
   // ----------------------------------------------------------------
   function automatic logic lanes_hit(input logic [3:0] be,
                                      input int         lo);
      lanes_hit = be[lo] | be[lo + 1];
   endfunction

   always_comb
   begin
      if (i_bus.addr == SPD_PDC_OFFSET)
         hit = 1'b1;
      else
         hit = 1'b0;
   end

   assign wr_hi = hit && i_bus.wr && lanes_hit(i_bus.byte_en, 2);
   assign wr_lo = hit && i_bus.wr && lanes_hit(i_bus.byte_en, 0);

   // ----------------------------------------------------------------
   // bus width strap
   // ----------------------------------------------------------------
   // caught while reset is held, so window writes follow the strap seen at reset
   always_ff @(posedge i_clk)
   begin
      if (i_reset)
         mode16_r <= i_bus16_mode;
   end

   // ----------------------------------------------------------------
   // register
   // ----------------------------------------------------------------
   // one process for the whole register keeps a single driver
   always_ff @(posedge i_clk)
   begin
      if (i_reset)
      begin
         if (i_bus16_mode)
            ctrl_r.wake_window <= SPD_WIN_RST_16;
         else
            ctrl_r.wake_window <= SPD_WIN_RST_32;
         ctrl_r.port3_pulldown_en              <= SPD_P3_PD_RST;
         ctrl_r.port2_pulldown_en              <= SPD_P2_PD_RST;
         ctrl_r.supply_detector_off_in_suspend <= SPD_DET_OFF_RST;
      end
      else
      begin
         if (wr_hi)
         begin
            // full 16-bit range written as is in 32-bit mode; 16-bit mode forces 1400h
            if (mode16_r)
               ctrl_r.wake_window <= SPD_WIN_FIX_16;
            else
               ctrl_r.wake_window <= i_bus.wdata[31:SPD_WIN_LSB];
         end
         if (wr_lo)
         begin
            ctrl_r.port3_pulldown_en <= i_bus.wdata[SPD_P3_PD_BIT];
            ctrl_r.port2_pulldown_en <= i_bus.wdata[SPD_P2_PD_BIT];
            ctrl_r.supply_detector_off_in_suspend <=
               i_bus.wdata[SPD_DET_OFF_BIT];
         end
      end
   end

   // reserved bits are not stored; leaves their write value to
   // software, and they read back as zero
   always_ff @(posedge i_clk)
   begin
      if (i_reset)
         o_rdata <= 32'h0000_0000;
      else if (hit && i_bus.rd)
         o_rdata <= {ctrl_r.wake_window, 3'b000,
                     ctrl_r.port3_pulldown_en,
                     ctrl_r.port2_pulldown_en,
                     ctrl_r.supply_detector_off_in_suspend, 10'h000};
      else
         o_rdata <= 32'h0000_0000;
   end

   // ----------------------------------------------------------------
   // slow clock edge
   // ----------------------------------------------------------------
   // one count per slow clock period
   // follows the pin through reset too, so a slow clock that is high
   // at release is not taken for a fresh edge
   always_ff @(posedge i_clk)
   begin
      slow_clk_r <= i_low_power_slow_clock;
   end

   assign slow_tick = i_low_power_slow_clock && !slow_clk_r;

   // ----------------------------------------------------------------
   // suspend sequencer
   // ----------------------------------------------------------------
   // zero window blocks every wake
   assign load = (state_r == SPD_ST_SUSPEND) && i_wake_event
                 && (ctrl_r.wake_window != 16'h0000);
   assign cancel = (state_r == SPD_ST_AWAKE) && i_resume_normal;

   always_ff @(posedge i_clk)
   begin
      if (i_reset)
         state_r <= SPD_ST_NORMAL;
      else
      begin
         case (state_r)
            SPD_ST_NORMAL:
            begin
               if (i_enter_suspend)
                  state_r <= SPD_ST_SUSPEND;
            end
            SPD_ST_SUSPEND:
            begin
               if (load)
                  state_r <= SPD_ST_AWAKE;
            end
            SPD_ST_AWAKE:
            begin
               if (i_resume_normal)
                  state_r <= SPD_ST_NORMAL;
               else if (expired)
                  state_r <= SPD_ST_SUSPEND;
            end
            default:
               state_r <= SPD_ST_NORMAL;
         endcase
      end
   end

   spd_wake_timer u_timer
   (
      .i_clk        (i_clk),
      .i_reset      (i_reset),
      .i_load       (load),
      .i_load_value (ctrl_r.wake_window),
      .i_cancel     (cancel),
      .i_slow_tick  (slow_tick),
      .o_running    (timer_running),
      .o_expired    (expired)
   );

   // ----------------------------------------------------------------
   // outputs
   // ----------------------------------------------------------------
   assign o_suspend           = (state_r == SPD_ST_SUSPEND);
   assign o_port3_pulldown_en = ctrl_r.port3_pulldown_en;
   assign o_port2_pulldown_en = ctrl_r.port2_pulldown_en;
   assign o_supply_detector_on =
      !(o_suspend && ctrl_r.supply_detector_off_in_suspend);

   // ----------------------------------------------------------------
   // checks
   // ----------------------------------------------------------------
   default clocking cb @(posedge i_clk); endclocking
   default disable iff (i_reset);

   AST_RST_WIN32: assert property (
      ($past(i_reset) && !mode16_r && !wr_hi)
      |-> (ctrl_r.wake_window == 16'h03e8))
      else $error("32-bit window reset value wrong");

   AST_RST_WIN16: assert property (
      ($past(i_reset) && mode16_r && !wr_hi)
      |-> (ctrl_r.wake_window == 16'h17e8))
      else $error("16-bit window reset value wrong");

   AST_WR16_FIX: assert property (
      (wr_hi && mode16_r) |=> (ctrl_r.wake_window == 16'h1400))
      else $error("16-bit write did not fix window");

   AST_WR32_WIN: assert property (
      (wr_hi && !mode16_r) |=> (ctrl_r.wake_window == $past(
         i_bus.wdata[31:16])))
      else $error("window field not written");

   AST_ZERO_WIN: assert property (
      (o_suspend && ctrl_r.wake_window == 16'h0000)
      |=> o_suspend)
      else $error("woke with zero window");

   AST_P3_PD: assert property (
      wr_lo |=> (o_port3_pulldown_en == $past(i_bus.wdata[12])))
      else $error("port 3 pull-down not following write");

   AST_P2_PD: assert property (
      wr_lo |=> (o_port2_pulldown_en == $past(i_bus.wdata[11])))
      else $error("port 2 pull-down not following write");

   AST_DET_OFF: assert property (
      (o_suspend && ctrl_r.supply_detector_off_in_suspend)
      |-> !o_supply_detector_on)
      else $error("detector powered in suspend");

   AST_CANCEL: assert property (
      cancel |=> (state_r == SPD_ST_NORMAL && !timer_running))
      else $error("countdown not cancelled");

   AST_REENTER: assert property (
      (state_r == SPD_ST_AWAKE && expired && !i_resume_normal)
      |=> o_suspend)
      else $error("expiry did not re-enter suspend");

   AST_UNMAPPED: assert property (
      (i_bus.rd && !hit) |=> (o_rdata == 32'h0000_0000))
      else $error("unmapped read not zero");

endmodule
`default_nettype wire

// File: hdl/spd_pkg.sv
// shared constants and types for the suspend power-down control block
package spd_pkg;

   // ----------------------------------------------------------------
   // register map
   // ----------------------------------------------------------------
   localparam logic [15:0] SPD_PDC_OFFSET    = 16'h0354;
   localparam int          SPD_WIN_LSB       = 16;
   localparam int          SPD_P3_PD_BIT     = 12;
   localparam int          SPD_P2_PD_BIT     = 11;
   localparam int          SPD_DET_OFF_BIT   = 10;

   // ----------------------------------------------------------------
   // reset values and fixed window loads
   // ----------------------------------------------------------------
   localparam logic [15:0] SPD_WIN_RST_32    = 16'h03e8;
   localparam logic [15:0] SPD_WIN_RST_16    = 16'h17e8;
   localparam logic [15:0] SPD_WIN_FIX_16    = 16'h1400;
   localparam logic        SPD_P3_PD_RST     = 1'b1;
   localparam logic        SPD_P2_PD_RST     = 1'b1;
   localparam logic        SPD_DET_OFF_RST   = 1'b0;

   // ----------------------------------------------------------------
   // timing: one window count is one slow clock period
   // ----------------------------------------------------------------
   localparam int          SPD_SLOW_CLK_KHZ  = 100;
   localparam int          SPD_COUNT_US      = 1000 / SPD_SLOW_CLK_KHZ;

   // ----------------------------------------------------------------
   // types
   // ----------------------------------------------------------------
   typedef enum logic [1:0] {
      SPD_ST_NORMAL,
      SPD_ST_SUSPEND,
      SPD_ST_AWAKE
   } spd_state_type;

   typedef struct packed {
      logic [15:0] wake_window;
      logic        port3_pulldown_en;
      logic        port2_pulldown_en;
      logic        supply_detector_off_in_suspend;
   } spd_ctrl_type;

   typedef struct packed {
      logic [15:0] addr;
      logic [3:0]  byte_en;
      logic [31:0] wdata;
      logic        wr;
      logic        rd;
   } spd_bus_type;

endpackage

// File: hdl/spd_wake_timer.sv
// wake-window down-counter stepped by the low-power slow clock
`timescale 1ns/1ps
`default_nettype none
module spd_wake_timer
(
   input  wire logic        i_clk,
   input  wire logic        i_reset,
   input  wire logic        i_load,
   input  wire logic [15:0] i_load_value,
   input  wire logic        i_cancel,
   input  wire logic        i_slow_tick,
   output logic             o_running,
   output logic             o_expired
);
   import spd_pkg::*;

   logic [15:0] count_r;
   logic        running_r;

   // ----------------------------------------------------------------
   // countdown
   // ----------------------------------------------------------------
   // load and count down
   always_ff @(posedge i_clk)
   begin
      if (i_reset || i_cancel)
      begin
         count_r   <= 16'h0000;
         running_r <= 1'b0;
      end
      else if (i_load)
      begin
         count_r   <= i_load_value;
         running_r <= (i_load_value != 16'h0000);
      end
      else if (running_r && i_slow_tick)
      begin
         count_r   <= count_r - 16'h0001;
         running_r <= (count_r != 16'h0001);
      end
   end

   always_ff @(posedge i_clk)
   begin
      if (i_reset || i_cancel || i_load)
         o_expired <= 1'b0;
      else
         o_expired <= running_r && i_slow_tick && (count_r == 16'h0001);
   end

   assign o_running = running_r;

   // ----------------------------------------------------------------
   // checks
   // ----------------------------------------------------------------
   default clocking cb @(posedge i_clk); endclocking
   default disable iff (i_reset);

   AST_TMR_LOAD: assert property (
      (i_load && !i_cancel) |=> (count_r == $past(i_load_value)))
      else $error("timer did not take the window value");

   AST_TMR_EXPIRE: assert property (
      (running_r && i_slow_tick && count_r == 16'h0001 && !i_load
       && !i_cancel) |=> (o_expired && !running_r))
      else $error("timer did not expire at zero");

endmodule
`default_nettype wire

// File: verification/test_spd_power_down_ctrl.sv
// self-checking testbench for the suspend power-down control block
`timescale 1ns/1ps
`default_nettype none
module test_spd_power_down_ctrl;
   import spd_pkg::*;
   // ---------------------------------------------------------------
   // signals
   // ---------------------------------------------------------------
   localparam int MAX_CYCLES = 4000;
   logic        i_clk;
   logic        i_reset;
   logic        i_bus16_mode;
   spd_bus_type i_bus;
   logic [31:0] o_rdata;
   logic        i_enter_suspend;
   logic        i_wake_event;
   logic        i_resume_normal;
   logic        i_low_power_slow_clock;
   logic        o_suspend;
   logic        o_port3_pulldown_en;
   logic        o_port2_pulldown_en;
   logic        o_supply_detector_on;
   int          mismatches = 0;
   int          samples_checked = 0;
   int          cycles = 0;
   logic [31:0] rd_val;

   spd_power_down_ctrl DUT
   (
      .i_clk                  (i_clk),
      .i_reset                (i_reset),
      .i_bus16_mode           (i_bus16_mode),
      .i_bus                  (i_bus),
      .o_rdata                (o_rdata),
      .i_enter_suspend        (i_enter_suspend),
      .i_wake_event           (i_wake_event),
      .i_resume_normal        (i_resume_normal),
      .i_low_power_slow_clock (i_low_power_slow_clock),
      .o_suspend              (o_suspend),
      .o_port3_pulldown_en    (o_port3_pulldown_en),
      .o_port2_pulldown_en    (o_port2_pulldown_en),
      .o_supply_detector_on   (o_supply_detector_on)
   );

   // ---------------------------------------------------------------
   // clock and hang guard
   // ---------------------------------------------------------------
   initial i_clk = 1'b0;
   always #20 i_clk = ~i_clk;

   always @(posedge i_clk)
   begin
      cycles <= cycles + 1;
      if (cycles == MAX_CYCLES)
      begin
         mismatches++;
         wrap_up();
      end
   end

   // ---------------------------------------------------------------
   // helpers
   // ---------------------------------------------------------------
   task automatic chk32(input string what, input logic [31:0] exp,
                        input logic [31:0] got);
      samples_checked++;
      if (got !== exp)
      begin
         mismatches++;
         $display("ERROR %s expected %h seen %h", what, exp, got);
      end
   endtask

   task automatic chk1(input string what, input logic exp, input logic got);
      samples_checked++;
      if (got !== exp)
      begin
         mismatches++;
         $display("ERROR %s expected %b seen %b", what, exp, got);
      end
   endtask

   // reserved bits always written as zero
   function automatic logic [31:0] reg_of(input logic [15:0] w,
      input logic b12, input logic b11, input logic b10);
      return {w, 3'h0, b12, b11, b10, 10'h000};
   endfunction

   task automatic bus_wr(input logic [15:0] a, input logic [31:0] d);
      @(posedge i_clk);
      i_bus.addr <= a;
      i_bus.wdata <= d;
      i_bus.wr <= 1'b1;
      @(posedge i_clk);
      i_bus.wr <= 1'b0;
      // let the register settle before anyone looks at it
      #1;
   endtask

   task automatic bus_rd(input logic [15:0] a);
      @(posedge i_clk);
      i_bus.addr <= a;
      i_bus.rd <= 1'b1;
      @(posedge i_clk);
      i_bus.rd <= 1'b0;
      #1 rd_val = o_rdata;
   endtask

   // one-cycle pulse: 0 enter suspend, 1 wake event, 2 resume normal
   task automatic pulse(input int sel);
      @(posedge i_clk);
      case (sel)
         0: i_enter_suspend <= 1'b1;
         1: i_wake_event <= 1'b1;
         default: i_resume_normal <= 1'b1;
      endcase
      @(posedge i_clk);
      i_enter_suspend <= 1'b0;
      i_wake_event <= 1'b0;
      i_resume_normal <= 1'b0;
      repeat (2) @(posedge i_clk);
      #1;
   endtask

   // shortened slow period; only its rising edges matter to the count
   task automatic slow_edge();
      @(posedge i_clk);
      i_low_power_slow_clock <= 1'b1;
      repeat (4) @(posedge i_clk);
      i_low_power_slow_clock <= 1'b0;
      repeat (4) @(posedge i_clk);
      #1;
   endtask

   task automatic wrap_up();
      $display("checks %0d mismatches %0d", samples_checked, mismatches);
      if (mismatches == 0 && samples_checked > 0)
         $display("All checks passed");
      else
         $display("Checks failed");
      $finish;
   endtask

   // ---------------------------------------------------------------
   // scenarios
   // ---------------------------------------------------------------
   task automatic test_reset_values();
      bus_rd(SPD_PDC_OFFSET);
      chk32("reset value", reg_of(SPD_WIN_RST_32, SPD_P3_PD_RST,
            SPD_P2_PD_RST, SPD_DET_OFF_RST), rd_val);
      chk1("detector on", 1'b1, o_supply_detector_on);
      chk1("port3 pulldown reset", 1'b1, o_port3_pulldown_en);
      $display("test reset values done");
   endtask

   task automatic test_register_access();
      bus_wr(SPD_PDC_OFFSET, reg_of(16'h0002, 1'b0, 1'b0, 1'b1));
      chk1("port3 pulldown", 1'b0, o_port3_pulldown_en);
      bus_wr(SPD_PDC_OFFSET, reg_of(16'h0002, 1'b1, 1'b0, 1'b1));
      chk1("port3 pulldown", 1'b1, o_port3_pulldown_en);
      chk1("port2 pulldown", 1'b0, o_port2_pulldown_en);
      bus_wr(16'h0358, 32'hffff_ffff);
      bus_rd(16'h0350);
      chk32("unmapped read", 32'h0000_0000, rd_val);
      bus_rd(SPD_PDC_OFFSET);
      chk32("window write", reg_of(16'h0002, 1'b1, 1'b0, 1'b1), rd_val);
      // low lanes only: the window must keep its value
      @(posedge i_clk);
      i_bus.byte_en <= 4'h3;
      bus_wr(SPD_PDC_OFFSET, reg_of(16'h0007, 1'b1, 1'b0, 1'b1));
      bus_rd(SPD_PDC_OFFSET);
      chk32("low lanes write", reg_of(16'h0002, 1'b1, 1'b0, 1'b1),
            rd_val);
      @(posedge i_clk);
      i_bus.byte_en <= 4'hf;
      $display("test register access done");
   endtask

   task automatic test_wake_expiry();
      pulse(0);
      chk1("suspended", 1'b1, o_suspend);
      chk1("detector in suspend", 1'b0, o_supply_detector_on);
      pulse(1);
      chk1("awake", 1'b0, o_suspend);
      chk1("detector awake", 1'b1, o_supply_detector_on);
      slow_edge();
      chk1("awake after one count", 1'b0, o_suspend);
      slow_edge();
      chk1("back in suspend", 1'b1, o_suspend);
      $display("test wake expiry done");
   endtask

   task automatic test_resume_cancel();
      pulse(1);
      pulse(2);
      repeat (3) slow_edge();
      chk1("resume holds normal", 1'b0, o_suspend);
      $display("test resume cancel done");
   endtask

   task automatic test_window_limits();
      bus_wr(SPD_PDC_OFFSET, reg_of(16'hffff, 1'b1, 1'b0, 1'b1));
      bus_rd(SPD_PDC_OFFSET);
      chk32("max window", reg_of(16'hffff, 1'b1, 1'b0, 1'b1), rd_val);
      bus_wr(SPD_PDC_OFFSET, reg_of(16'h0000, 1'b1, 1'b0, 1'b1));
      pulse(0);
      pulse(1);
      slow_edge();
      chk1("zero window stays", 1'b1, o_suspend);
      $display("test window limits done");
   endtask

   task automatic test_bus16_mode();
      @(posedge i_clk);
      i_bus16_mode <= 1'b1;
      i_reset <= 1'b1;
      repeat (2) @(posedge i_clk);
      i_reset <= 1'b0;
      bus_rd(SPD_PDC_OFFSET);
      chk32("reset 16-bit", reg_of(SPD_WIN_RST_16, SPD_P3_PD_RST,
            SPD_P2_PD_RST, SPD_DET_OFF_RST), rd_val);
      chk1("normal after reset", 1'b0, o_suspend);
      bus_wr(SPD_PDC_OFFSET, reg_of(16'hffff, 1'b1, 1'b1, 1'b0));
      bus_rd(SPD_PDC_OFFSET);
      chk32("16-bit window", reg_of(SPD_WIN_FIX_16, 1'b1, 1'b1, 1'b0),
            rd_val);
      chk1("port2 pulldown set", 1'b1, o_port2_pulldown_en);
      $display("test 16-bit mode done");
   endtask

   // ---------------------------------------------------------------
   // main sequence
   // ---------------------------------------------------------------
   initial
   begin
      i_reset = 1'b1;
      i_bus16_mode = 1'b0;
      i_bus = '0;
      i_bus.byte_en = 4'hf;
      i_enter_suspend = 1'b0;
      i_wake_event = 1'b0;
      i_resume_normal = 1'b0;
      i_low_power_slow_clock = 1'b0;
      repeat (2) @(posedge i_clk);
      i_reset <= 1'b0;
      test_reset_values();
      test_register_access();
      test_wake_expiry();
      test_resume_cancel();
      test_window_limits();
      test_bus16_mode();
      wrap_up();
   end
endmodule
`default_nettype wire
